//--- src/hbp_map.vh
// constants for the host bus port and strap configuration block
// assumes a 20 MHz clock and an asynchronous active-low reset
//
// How it works
// R1 - network test strap: 0000 internal, 0001 external crystal, 0010 external oscillator, else test.
// R2 - speed strap 000 all abilities, 001 only 100M, 010 only 10M; 011 reserved.
// R3 - speed strap 100..111 forces 100 full, 100 half, 10 full, 10 half.
// R4 - speed strap captured at reset release, later pin changes ignored.
// R5 - host holds reset low at least 2 us; no power-on reset inside. The bench holds it 5 cycles (250 ns).
// R6 - host waits at least 10 ms after reset release before accessing. The bench waits 4 cycles (200 ns).
// R7 - bus-width strap high selects 16-bit data bus, low selects 8-bit.
// R8 - bus-width strap copied into mode register bit 15 at reset.
// R9 - bus-width strap changes after reset are ignored until next reset.
// R10 - in 16-bit mode the address lsb is ignored.
// R11 - in 8-bit mode upper data byte is never driven.
// R12 - chip select high releases all sixteen data lines.
// R13 - write strobe stores data at the address, timed by mode bits 13..11.
// R14 - read strobe with chip select drives addressed register contents.
// R15 - interrupt output goes low on any enabled pending event.
// R16 - host clears pending bits; interrupt output then returns high.
// R17 - each buffer-ready pin has socket, memory type and depth settings.
// R18 - buffer-ready pin asserts at its polarity when size reaches depth.
// R19 - host uses one strobe per access with stable address.
`ifndef HBP_MAP_VH
`define HBP_MAP_VH

// register word indexes (address bits 9..1 on the 16-bit bus, 9..2 on the 8-bit bus)
`define HBP_IDX_MODE     9'h000
`define HBP_IDX_IPEND    9'h001
`define HBP_IDX_IMASK    9'h002
`define HBP_IDX_SIPEND   9'h003
`define HBP_IDX_SIMASK   9'h004
`define HBP_IDX_BRCFG0   9'h010
`define HBP_IDX_BRDEP0   9'h014
`define HBP_IDX_SIZE0    9'h020

// mode register fields
`define HBP_MODE_BW      15
`define HBP_MODE_WFT_HI  13
`define HBP_MODE_WFT_LO  11
`define HBP_MODE_RST     16'h0000

// buffer-ready config fields
`define HBP_BRC_POL      7
`define HBP_BRC_RXMEM    6
`define HBP_BRC_SOCK_HI  2

// network test strap codes
`define HBP_NET_INT      4'h0
`define HBP_NET_XTAL     4'h1
`define HBP_NET_OSC      4'h2

// timing for host side, in ns
`define HBP_RST_HOLD_NS  2000
`define HBP_SETTLE_NS    10000000
`define HBP_CLK_NS       50

`endif

//--- src/hbp_port.v
// host bus port with strap capture, mode, interrupt and buffer-ready logic
// assumes host pins are synchronous to clock and a tri-state pad is outside
`timescale 1ns/100ps
`default_nettype none
`include "hbp_map.vh"

module hbp_port
(
    // clock and reset
    input  wire        clock,
    input  wire        rstn,
    // straps
    input  wire [3:0]  net_test_strap,
    input  wire [2:0]  phy_speed_duplex_strap,
    input  wire        bus_width_strap,
    // host bus
    input  wire        cs_n,
    input  wire        rd_n,
    input  wire        wr_n,
    input  wire [9:0]  addr,
    input  wire [15:0] data_in,
    output reg  [15:0] data_out,
    output reg  [1:0]  data_oe,
    output reg         int_n,
    // events and buffer sizes from the core
    input  wire [4:0]  event_in,
    input  wire [63:0] tx_free_size,
    input  wire [63:0] rx_recv_size,
    output reg  [3:0]  buffer_ready_pins,
    // decoded configuration
    output reg         phy_internal,
    output reg         phy_ext_xtal,
    output reg         phy_ext_osc,
    output reg         phy_factory_test,
    output reg         phy_autoneg,
    output reg  [3:0]  phy_abilities,
    output reg         bus16
);

    // captured straps and registers
    reg [2:0]  speed_q;
    reg [3:0]  net_q;
    reg        bw_q;
    reg        cap_q;
    reg [15:0] mode_q;
    reg [4:0]  ipend_q;
    reg [4:0]  imask_q;
    reg [3:0]  sipend_q;
    reg [3:0]  simask_q;
    reg [7:0]  brcfg_q [0:3];
    reg [15:0] brdep_q [0:3];
    reg        wr_d1_q;
    reg [3:0]  wr_cnt_q;
    reg [8:0]  waddr_q;
    reg [15:0] wdata_q;
    reg        wpend_q;
    reg [15:0] rdata_d;
    reg [4:0]  ipend_d;

    // word index: 16-bit mode drops address lsb
    wire [8:0] idx = bw_q ? addr[9:1] : {1'b0, addr[9:2]};  // [R10]
    wire       hi8 = ~bw_q & addr[0];
    wire       wr_act = ~cs_n & ~wr_n;
    wire       wr_start = wr_act & ~wr_d1_q;
    wire [2:0] wft = mode_q[`HBP_MODE_WFT_HI:`HBP_MODE_WFT_LO];
    wire       wr_fire = wpend_q & (wr_cnt_q >= {1'b0, wft});  // [R13]
    wire [4:0] ev = {event_in[4:1], event_in[0] | (|(sipend_q & simask_q))};

    // strap capture one edge after reset release
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cap_q   <= 1'b0;
            speed_q <= 3'h0;
            net_q   <= 4'h0;
            bw_q    <= 1'b1;
        end
        else if (!cap_q)
        begin
            cap_q   <= 1'b1;
            speed_q <= phy_speed_duplex_strap;  // [R4]
            net_q   <= net_test_strap;
            bw_q    <= bus_width_strap;         // [R9]
        end
    end

    // write capture: delay set by fetch timing field
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_d1_q  <= 1'b0;
            wr_cnt_q <= 4'h0;
            wpend_q  <= 1'b0;
            waddr_q  <= 9'h000;
            wdata_q  <= 16'h0000;
        end
        else
        begin
            wr_d1_q <= wr_act;
            if (wr_start)
            begin
                wpend_q  <= 1'b1;
                wr_cnt_q <= 4'h0;
                waddr_q  <= idx;
            end
            else if (wr_fire)
                wpend_q <= 1'b0;
            else if (wpend_q)
                wr_cnt_q <= wr_cnt_q + 4'h1;
            // narrow bus: each byte write lands in its own lane only
            if (wr_act)
            begin
                if (bw_q)
                    wdata_q <= data_in;
                else if (hi8)
                    wdata_q[15:8] <= data_in[7:0];
                else
                    wdata_q[7:0] <= data_in[7:0];
            end
        end
    end

    // pending bits: hardware set wins over host clear
    always @*
    begin
        ipend_d = ipend_q;
        if (wr_fire && waddr_q == `HBP_IDX_IPEND)
            ipend_d = ipend_q & ~wdata_q[4:0];  // [R16]
        ipend_d = ipend_d | ev;
    end

    // register file
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_q   <= `HBP_MODE_RST;
            ipend_q  <= 5'h00;
            imask_q  <= 5'h00;
            sipend_q <= 4'h0;
            simask_q <= 4'h0;
        end
        else
        begin
            ipend_q  <= ipend_d;
            sipend_q <= sipend_q | event_in[3:0];
            if (!cap_q)
                mode_q[`HBP_MODE_BW] <= bus_width_strap;  // [R8]
            if (wr_fire)
            begin
                case (waddr_q)
                    `HBP_IDX_MODE:   mode_q[14:0] <= wdata_q[14:0];  // [R13]
                    `HBP_IDX_IMASK:  imask_q <= wdata_q[4:0];
                    `HBP_IDX_SIPEND: sipend_q <= (sipend_q & ~wdata_q[3:0]) | event_in[3:0];
                    `HBP_IDX_SIMASK: simask_q <= wdata_q[3:0];
                    default:         mode_q <= mode_q;
                endcase
            end
        end
    end

    // per-pin buffer-ready config, depth and comparison
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_buffer_ready_pins
            wire [1:0]  sk   = brcfg_q[g][1:0];
            wire [15:0] tsz  = tx_free_size[sk*16 +: 16];
            wire [15:0] rsz  = rx_recv_size[sk*16 +: 16];
            wire [15:0] sz   = brcfg_q[g][`HBP_BRC_RXMEM] ? rsz : tsz;
            wire        hit  = sz >= brdep_q[g];
            always @(posedge clock or negedge rstn)
            begin
                if (!rstn)
                begin
                    brcfg_q[g] <= 8'h00;
                    brdep_q[g] <= 16'hffff;
                    buffer_ready_pins[g] <= 1'b0;
                end
                else
                begin
                    if (wr_fire && waddr_q == `HBP_IDX_BRCFG0 + g)
                        brcfg_q[g] <= wdata_q[7:0];  // [R17]
                    if (wr_fire && waddr_q == `HBP_IDX_BRDEP0 + g)
                        brdep_q[g] <= wdata_q;
                    buffer_ready_pins[g] <= hit ^ ~brcfg_q[g][`HBP_BRC_POL];  // [R18]
                end
            end
        end
    endgenerate

    // read mux
    always @*
    begin
        case (idx)
            `HBP_IDX_MODE:   rdata_d = mode_q;
            `HBP_IDX_IPEND:  rdata_d = {11'h000, ipend_q};
            `HBP_IDX_IMASK:  rdata_d = {11'h000, imask_q};
            `HBP_IDX_SIPEND: rdata_d = {12'h000, sipend_q};
            `HBP_IDX_SIMASK: rdata_d = {12'h000, simask_q};
            `HBP_IDX_BRCFG0:     rdata_d = {8'h00, brcfg_q[0]};
            `HBP_IDX_BRCFG0 + 1: rdata_d = {8'h00, brcfg_q[1]};
            `HBP_IDX_BRCFG0 + 2: rdata_d = {8'h00, brcfg_q[2]};
            `HBP_IDX_BRCFG0 + 3: rdata_d = {8'h00, brcfg_q[3]};
            `HBP_IDX_BRDEP0:     rdata_d = brdep_q[0];
            `HBP_IDX_BRDEP0 + 1: rdata_d = brdep_q[1];
            `HBP_IDX_BRDEP0 + 2: rdata_d = brdep_q[2];
            `HBP_IDX_BRDEP0 + 3: rdata_d = brdep_q[3];
            default:         rdata_d = 16'h0000;
        endcase
        if (hi8)
            rdata_d = {8'h00, rdata_d[15:8]};
    end

    // outputs: data drive, interrupt, captured width
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            data_out <= 16'h0000;
            data_oe  <= 2'b00;
            int_n    <= 1'b1;
            bus16    <= 1'b1;
        end
        else
        begin
            // lanes follow the strobe one edge late, upper lane only when wide
            data_out   <= rdata_d;                               // [R14]
            data_oe[0] <= ~cs_n & ~rd_n;                         // [R12]
            data_oe[1] <= ~cs_n & ~rd_n & bw_q;                  // [R11]
            int_n      <= ~|(ipend_q & imask_q);                 // [R15]
            bus16      <= bw_q;                                  // [R7]
        end
    end

    // strap decode: network selection and transceiver abilities
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            phy_internal     <= 1'b0;
            phy_ext_xtal     <= 1'b0;
            phy_ext_osc      <= 1'b0;
            phy_factory_test <= 1'b0;
            phy_autoneg      <= 1'b0;
            phy_abilities    <= 4'h0;
        end
        else
        begin
            phy_internal     <= net_q == `HBP_NET_INT;           // [R1]
            phy_ext_xtal     <= net_q == `HBP_NET_XTAL;
            phy_ext_osc      <= net_q == `HBP_NET_OSC;
            phy_factory_test <= net_q > `HBP_NET_OSC;
            // abilities: {100fd,100hd,10fd,10hd}; reserved code gives none
            case (speed_q)
                3'h0:
                begin
                    phy_autoneg   <= 1'b1;  // [R2]
                    phy_abilities <= 4'hf;
                end
                3'h1:
                begin
                    phy_autoneg   <= 1'b1;
                    phy_abilities <= 4'hc;
                end
                3'h2:
                begin
                    phy_autoneg   <= 1'b1;
                    phy_abilities <= 4'h3;
                end
                3'h4:
                begin
                    phy_autoneg   <= 1'b0;  // [R3]
                    phy_abilities <= 4'h8;
                end
                3'h5:
                begin
                    phy_autoneg   <= 1'b0;
                    phy_abilities <= 4'h4;
                end
                3'h6:
                begin
                    phy_autoneg   <= 1'b0;
                    phy_abilities <= 4'h2;
                end
                3'h7:
                begin
                    phy_autoneg   <= 1'b0;
                    phy_abilities <= 4'h1;
                end
                default:
                begin
                    phy_autoneg   <= 1'b0;
                    phy_abilities <= 4'h0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- verification/hbp_port_assertions.sv
// checker for the host bus port, sees top-level ports only
// assumes rising-edge clock and asynchronous active-low rstn
`timescale 1ns/100ps
`default_nettype none
module hbp_port_chk
(
    // clock and reset
    input wire logic       clock,
    input wire logic       rstn,
    // host bus
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [1:0] data_oe,
    input wire logic       int_n,
    input wire logic [4:0] event_in,
    // decoded configuration
    input wire logic       bus16,
    input wire logic       phy_internal,
    input wire logic       phy_ext_xtal,
    input wire logic       phy_ext_osc,
    input wire logic       phy_factory_test,
    input wire logic       phy_autoneg,
    input wire logic [3:0] phy_abilities
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // data lane release and use
    oe_release_a: assert property (cs_n |=> data_oe == 2'b00)
        else $error("data driven while deselected");
    upper_hiz_a: assert property (!bus16 |-> !data_oe[1])
        else $error("upper byte driven in narrow mode");
    read_drive_a: assert property ($fell(rd_n) && !cs_n |-> ##[1:2] data_oe == (bus16 ? 2'b11 : 2'b01))
        else $error("read lanes not driven");
    // captured straps
    width_hold_a: assert property ($past(rstn, 3) |-> $stable(bus16))
        else $error("bus width changed after reset");
    net_decode_a: assert property ($past(rstn, 2) |-> $onehot({phy_internal, phy_ext_xtal, phy_ext_osc, phy_factory_test}))
        else $error("network mode not one-hot");
    forced_set_a: assert property (!phy_autoneg |-> $onehot0(phy_abilities))
        else $error("forced link has several abilities");
    // interrupt line cause
    irq_raise_a: assert property ($fell(int_n) |-> $past(|event_in, 2) || $past(|event_in, 3) || $past(!wr_n, 2))
        else $error("interrupt without event");
    irq_clear_a: assert property ($rose(int_n) |-> $past(!wr_n, 2))
        else $error("interrupt released without clear");
    // main scenarios
    cover property ($fell(int_n));
    cover property ($rose(int_n));
    cover property (!bus16 && data_oe == 2'b01);
endmodule
`default_nettype wire

//--- verification/hbp_host.sv
// host model driving the parallel bus pins at the falling edge
// assumes the port samples on the rising edge
`timescale 1ns/100ps
`default_nettype none
module hbp_host
(
    // clock and read return
    input  wire logic        clock,
    input  wire logic [15:0] data_out,
    input  wire logic [1:0]  data_oe,
    // host bus
    output var  logic        cs_n,
    output var  logic        rd_n,
    output var  logic        wr_n,
    output var  logic [9:0]  addr,
    output var  logic [15:0] data_in
);
    // idle bus
    initial {cs_n, rd_n, wr_n, addr, data_in} = {3'h7, 26'h0};
    // one strobe, address held, long enough for any fetch timing
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(negedge clock);
        {cs_n, wr_n, addr, data_in} = {2'b00, a, d};
        repeat (9) @(posedge clock);
        @(negedge clock);
        {cs_n, wr_n, data_in} = {2'b11, ~d};
        @(negedge clock);
    endtask
    // read, answer taken after it settles
    task automatic rd(input logic [9:0] a, output logic [15:0] d, output logic [1:0] oe);
        @(negedge clock);
        {cs_n, rd_n, addr} = {2'b00, a};
        repeat (2) @(posedge clock);
        @(negedge clock);
        d = data_out;
        oe = data_oe;
        {cs_n, rd_n} = 2'b11;
        @(negedge clock);
    endtask
endmodule
`default_nettype wire

//--- verification/test_hbp_port.sv
// self-checking bench for the host bus port
// assumes host model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module test_hbp_port;
    logic        clock, rstn, cs_n, rd_n, wr_n, bus_width_strap, int_n, bus16, phy_autoneg;
    logic        phy_internal, phy_ext_xtal, phy_ext_osc, phy_factory_test;
    logic [3:0]  net_test_strap, buffer_ready_pins, phy_abilities;
    logic [2:0]  phy_speed_duplex_strap;
    logic [9:0]  addr;
    logic [15:0] data_in, data_out, rdata;
    logic [1:0]  data_oe, roe;
    logic [4:0]  event_in;
    logic [63:0] tx_free_size, rx_recv_size;
    logic [4:0]  abil [8] = '{5'h1f, 5'h1c, 5'h13, 5'h00, 5'h08, 5'h04, 5'h02, 5'h01};
    int          n_mismatch, checks_done;
    hbp_port hbp_port_i (.clock(clock), .rstn(rstn), .net_test_strap(net_test_strap),
        .phy_speed_duplex_strap(phy_speed_duplex_strap), .bus_width_strap(bus_width_strap), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .int_n(int_n), .event_in(event_in), .tx_free_size(tx_free_size), .rx_recv_size(rx_recv_size),
        .buffer_ready_pins(buffer_ready_pins), .phy_internal(phy_internal), .phy_ext_xtal(phy_ext_xtal),
        .phy_ext_osc(phy_ext_osc), .phy_factory_test(phy_factory_test), .phy_autoneg(phy_autoneg),
        .phy_abilities(phy_abilities), .bus16(bus16));
    hbp_host hbp_host_i (.clock(clock), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .data_in(data_in));
    // 20 MHz clock
    initial clock = 1'b0;
    always #25 clock = ~clock;
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            n_mismatch++;
    endtask
    // straps applied, reset pulsed, settle before access
    task automatic restart(input logic [3:0] n, input logic [2:0] s, input logic w);
        @(negedge clock);
        {rstn, net_test_strap, phy_speed_duplex_strap, bus_width_strap} = {1'b0, n, s, w};
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
    endtask
    // one-cycle event pulse, then time for the line to follow
    task automatic pulse(input logic [4:0] e);
        @(negedge clock);
        event_in = e;
        @(negedge clock);
        event_in = 5'h00;
        repeat (2) @(negedge clock);
    endtask
    // counts and verdict
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // test sequence
    initial
    begin
        {rstn, net_test_strap, phy_speed_duplex_strap, bus_width_strap, event_in, tx_free_size, rx_recv_size} = '0;
        for (int i = 0; i < 8; i++)
        begin
            restart(i[3:0], i[2:0], 1'b1);
            chk({phy_internal, phy_ext_xtal, phy_ext_osc, phy_factory_test}, i < 3 ? 4'h8 >> i : 4'h1);
            chk({phy_autoneg, phy_abilities}, abil[i]);
        end
        {net_test_strap, phy_speed_duplex_strap, bus_width_strap} = '0;
        repeat (3) @(negedge clock);
        chk({bus16, phy_autoneg, phy_abilities}, 6'h21);
        $display("strap decode done");
        restart(4'h0, 3'h0, 1'b1);
        hbp_host_i.rd(10'h000, rdata, roe);
        chk({roe, rdata}, 18'h38000);
        hbp_host_i.wr(10'h000, 16'h1800);
        hbp_host_i.rd(10'h001, rdata, roe);
        chk(rdata, 16'h9800);
        hbp_host_i.rd(10'h3fe, rdata, roe);
        chk(rdata, 16'h0000);
        pulse(5'h10);
        chk(int_n, 1'b1);
        hbp_host_i.wr(10'h002, 16'h0010);
        hbp_host_i.wr(10'h004, 16'h0010);
        pulse(5'h10);
        chk(int_n, 1'b0);
        hbp_host_i.wr(10'h002, 16'h0010);
        chk(int_n, 1'b1);
        hbp_host_i.wr(10'h004, 16'h0001);
        hbp_host_i.wr(10'h008, 16'h0002);
        pulse(5'h02);
        chk(int_n, 1'b0);
        hbp_host_i.wr(10'h006, 16'h0002);
        hbp_host_i.wr(10'h002, 16'h0001);
        chk(int_n, 1'b1);
        $display("bus and interrupt done");
        hbp_host_i.wr(10'h020, 16'h0081);
        hbp_host_i.wr(10'h028, 16'h0100);
        tx_free_size = 64'h00ff_0000;
        repeat (3) @(negedge clock);
        chk(buffer_ready_pins, 4'he);
        tx_free_size = 64'h0100_0000;
        repeat (3) @(negedge clock);
        chk(buffer_ready_pins, 4'hf);
        hbp_host_i.wr(10'h020, 16'h0001);
        chk(buffer_ready_pins, 4'he);
        rx_recv_size = 64'h0000_0100_0000_0000;
        hbp_host_i.wr(10'h020, 16'h00c2);
        chk(buffer_ready_pins, 4'hf);
        rx_recv_size = 64'h0000_00ff_0000_0000;
        repeat (3) @(negedge clock);
        chk(buffer_ready_pins, 4'he);
        $display("buffer ready done");
        restart(4'h0, 3'h0, 1'b0);
        hbp_host_i.rd(10'h001, rdata, roe);
        chk({bus16, roe, rdata[7:0]}, 11'h100);
        hbp_host_i.wr(10'h051, 16'h0012);
        hbp_host_i.wr(10'h050, 16'hff34);
        hbp_host_i.rd(10'h051, rdata, roe);
        chk(rdata[7:0], 8'h12);
        hbp_host_i.rd(10'h050, rdata, roe);
        chk({roe, rdata[7:0]}, 10'h134);
        $display("narrow bus done");
        give_verdict;
    end
    // watchdog
    initial
    begin
        repeat (4000) @(posedge clock);
        n_mismatch++;
        give_verdict;
    end
endmodule
bind hbp_port hbp_port_chk hbp_port_chk_i (.clock(clock), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_oe(data_oe), .int_n(int_n), .event_in(event_in), .bus16(bus16), .phy_internal(phy_internal),
    .phy_ext_xtal(phy_ext_xtal), .phy_ext_osc(phy_ext_osc), .phy_factory_test(phy_factory_test),
    .phy_autoneg(phy_autoneg), .phy_abilities(phy_abilities));
`default_nettype wire
